// ===== include/afsl_pkg.sv
/*
  Package of the converter-pair frame builder: register map, frame
  layout, control characters, 8b/10b tables and shared functions.
  Assumes a 100 MHz clock and a 32-bit classic Wishbone master.
*/
package afsl_pkg;
    // Register byte addresses
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STAT = 8'h04;
    localparam logic [7:0] ADDR_FRAMES = 8'h08;
    // Control field positions and reset values
    localparam int CTRL_FMT_LSB = 0;
    localparam int CTRL_EMPH_EN = 2;
    localparam int CTRL_EMPH_LSB = 4;
    localparam int CTRL_LINK_RST = 8;
    localparam logic [1:0] FMT_RST = 2'h0;
    localparam logic EMPH_EN_RST = 1'b1;
    localparam logic [2:0] EMPH_LVL_RST = 3'h4;
    // Frame formats
    localparam logic [1:0] FMT_12 = 2'h0;
    localparam logic [1:0] FMT_14 = 2'h1;
    localparam logic [1:0] FMT_TEST = 2'h2;
    localparam logic [1:0] FMT_RAW = 2'h3;
    localparam logic [5:0] NB_12 = 6'h30;
    localparam logic [5:0] NB_14 = 6'h38;
    localparam logic [5:0] NB_RAW = 6'h3c;
    // Control characters, sent with the K flag set
    localparam logic [7:0] K28_0 = 8'h1c;
    localparam logic [7:0] K28_1 = 8'h3c;
    localparam logic [7:0] K28_2 = 8'h5c;
    localparam logic [7:0] K28_3 = 8'h7c;
    localparam logic [7:0] K28_5 = 8'hbc;
    localparam logic [7:0] K28_6 = 8'hdc;
    // Runs, character length and stream length
    localparam logic [4:0] SYNC_RUN = 5'h10;
    localparam logic [4:0] COMMA_RUN = 5'h04;
    localparam logic [3:0] CHAR_LAST = 4'h9;
    localparam logic [4:0] CAP_LAST = 5'h1f;
    // 8b/10b tables, negative running disparity column
    localparam logic [0:31][5:0] T6 = {6'h27, 6'h1d, 6'h2d, 6'h31, 6'h35,
        6'h29, 6'h19, 6'h38, 6'h39, 6'h25, 6'h15, 6'h34, 6'h0d, 6'h2c,
        6'h1c, 6'h17, 6'h1b, 6'h23, 6'h13, 6'h32, 6'h0b, 6'h2a, 6'h1a,
        6'h3a, 6'h33, 6'h26, 6'h16, 6'h36, 6'h0e, 6'h2e, 6'h1e, 6'h2b};
    localparam logic [0:7][3:0] T4D = {4'hb, 4'h9, 4'h5, 4'hc, 4'hd, 4'ha,
        4'h6, 4'he};
    localparam logic [0:7][3:0] T4K = {4'h4, 4'h9, 4'h5, 4'h3, 4'h2, 4'ha,
        4'h6, 4'h8};
    localparam logic [5:0] K28_6B = 6'h0f;
    localparam logic [3:0] A7_4B = 4'h7;

    typedef enum logic [2:0] {ST_SYNC, ST_IDLE, ST_HEAD, ST_STAMP, ST_DATA,
        ST_PAR0, ST_PAR1, ST_COMMA} afsl_state_t;

    function automatic logic [5:0] afsl_nbytes(input logic [1:0] fmt);
        case (fmt)
            FMT_14: return NB_14;
            FMT_RAW: return NB_RAW;
            default: return NB_12;
        endcase
    endfunction

    // Returns {new running disparity, abcdeifghj}, bit a sent first
    function automatic logic [10:0] afsl_enc(input logic [7:0] d,
        input logic k, input logic rd);
        logic [5:0] c6;
        logic [3:0] c4;
        logic rd_mid;
        logic alt;
        c6 = k ? K28_6B : T6[d[4:0]];
        if (rd && ($countones(c6) != 3 || c6 == 6'h38))
            c6 = ~c6;
        rd_mid = rd ^ ($countones(c6) != 3);
        alt = (d[7:5] == 3'h7) && ((!rd_mid && (d[4:0] == 5'h11 ||
            d[4:0] == 5'h12 || d[4:0] == 5'h14)) || (rd_mid &&
            (d[4:0] == 5'h0b || d[4:0] == 5'h0d || d[4:0] == 5'h0e)));
        if (k)
            c4 = rd ? ~T4K[d[7:5]] : T4K[d[7:5]];
        else
        begin
            c4 = alt ? A7_4B : T4D[d[7:5]];
            if (rd_mid && ($countones(c4) != 2 || c4 == 4'hc))
                c4 = ~c4;
        end
        return {rd ^ ($countones({c6, c4}) != 5), c6, c4};
    endfunction
endpackage

// ===== include/afsl_cap_if.sv
/*
  Carrier between the frame builder and one stream capture unit.
  Assumes both ends run on the same clock; inputs already synchronised.
*/
`timescale 1ns/1ps
`default_nettype none
interface afsl_cap_if;
    logic strobe_edge;
    logic marker;
    logic [7:0] data;
    logic [255:0] words;
    logic valid;
    modport cap (input strobe_edge, input marker, input data,
        output words, output valid);
    modport hub (output strobe_edge, output marker, output data,
        input words, input valid);
endinterface
`default_nettype wire

// ===== design/afsl_capture.sv
/*
  Capture of one converter: eight serial streams, 32 bits each per
  sample period, giving sixteen 16-bit words.
  Assumes strobe edges and bits arrive synchronised and far slower
  than the clock.
*/
`timescale 1ns/1ps
`default_nettype none
module afsl_capture
    import afsl_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Stream bits in, words out
    afsl_cap_if.cap cap
);
    logic [7:0][31:0] sh_r;
    logic [7:0][31:0] sh_nxt;
    logic [4:0] cnt_r;
    logic [4:0] cnt_nxt;
    logic lock_r;
    logic lock_nxt;
    logic [255:0] words_r;
    logic [255:0] words_nxt;
    logic valid_r;
    logic valid_nxt;

    always_comb
    begin
        sh_nxt = sh_r;
        cnt_nxt = cnt_r;
        lock_nxt = lock_r;
        words_nxt = words_r;
        valid_nxt = 1'b0;
        if (cap.strobe_edge)
        begin
            for (int s = 0; s < 8; s++)
                sh_nxt[s] = {sh_r[s][30:0], cap.data[s]};
            // Nothing is delivered until the first period marker
            if (cap.marker)
            begin
                lock_nxt = 1'b1;
                cnt_nxt = 5'h01;
            end
            else
                cnt_nxt = cnt_r + 5'h01;
            if (lock_r && !cap.marker && cnt_r == CAP_LAST)
            begin
                valid_nxt = 1'b1;
                for (int s = 0; s < 8; s++)
                    words_nxt[255 - 32 * s -: 32] = sh_nxt[s];
            end
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            sh_r <= '0;
            cnt_r <= 5'h00;
            lock_r <= 1'b0;
            words_r <= '0;
            valid_r <= 1'b0;
        end
        else
        begin
            sh_r <= sh_nxt;
            cnt_r <= cnt_nxt;
            lock_r <= lock_nxt;
            words_r <= words_nxt;
            valid_r <= valid_nxt;
        end
    end

    assign cap.words = words_r;
    assign cap.valid = valid_r;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    a_cap_period_done: assert property (
        cap.strobe_edge && lock_r && !cap.marker && cnt_r == CAP_LAST
        |=> valid_r ##1 !valid_r)
        else $error("capture missed end of sample period");
endmodule
`default_nettype wire

// ===== design/afsl_framer.sv
/*
  Frame builder for one converter pair: input synchronisers, frame
  formation, 8b/10b encoding, two-half bit serializer with pre-emphasis
  control, and a classic Wishbone register slave.
  Assumes one 100 MHz clock, converter pins asynchronous to it, and a
  fast-command decoder on the same clock giving the sync pulse.
*/
// Local design decisions: the address map and register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
module afsl_framer
    import afsl_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Converter pins, converter 0 in the low half
    input wire logic [15:0] conv_stream_i,
    input wire logic [1:0] converter_strobe_clock_i,
    input wire logic [1:0] sample_period_marker_i,
    input wire logic sampling_clock_i,
    // Fast-command decoder, same clock
    input wire logic sync_cmd_i,
    // Serial line
    output logic tx_bit_o,
    output logic emph_pulse_o,
    output logic emph_en_o,
    output logic [2:0] emph_level_o
);
    logic [20:0] meta_r;
    logic [20:0] sync_r;
    logic [20:0] prev_r;
    afsl_state_t state_r;
    afsl_state_t state_nxt;
    logic [4:0] run_r;
    logic [4:0] run_nxt;
    logic [5:0] cnt_r;
    logic [5:0] cnt_nxt;
    logic [479:0] frame_r;
    logic [479:0] frame_nxt;
    logic [15:0] par_r;
    logic [15:0] par_nxt;
    logic [7:0] tsf_r;
    logic [7:0] tsf_nxt;
    logic [1:0] fmtf_r;
    logic [1:0] fmtf_nxt;
    logic [1:0] pend_r;
    logic [1:0] pend_nxt;
    logic [511:0] buf_r;
    logic [511:0] buf_nxt;
    logic rd_r;
    logic rd_nxt;
    logic [15:0] frames_r;
    logic [15:0] frames_nxt;
    logic [3:0] bit_r;
    logic [3:0] bit_nxt;
    logic [4:0] even_r;
    logic [4:0] even_nxt;
    logic [4:0] odd_r;
    logic [4:0] odd_nxt;
    logic tx_r;
    logic tx_nxt;
    logic emph_r;
    logic emph_nxt;
    logic [7:0] ts_r;
    logic [7:0] ts_nxt;
    logic [1:0] fmt_r;
    logic [1:0] fmt_nxt;
    logic emph_en_r;
    logic emph_en_nxt;
    logic [2:0] lvl_r;
    logic [2:0] lvl_nxt;
    logic ack_r;
    logic ack_nxt;
    logic [31:0] dat_r;
    logic [31:0] dat_nxt;
    logic take;
    logic wb_wr;
    logic link_rst;
    logic samp_edge;
    logic [7:0] ch;
    logic chk;
    logic [10:0] enc;

    // Sample words are built from converter 0 then converter 1
    function automatic logic [479:0] afsl_pack(input logic [511:0] w,
        input logic [1:0] fmt);
        logic [479:0] p;
        p = '0;
        for (int n = 0; n < 32; n++)
        begin
            case (fmt)
                FMT_12: p[479 - 12 * n -: 12] = w[511 - 16 * n -: 12];
                FMT_14: p[479 - 14 * n -: 14] = w[511 - 16 * n -: 14];
                FMT_RAW: p[479 - 15 * n -: 15] = w[510 - 16 * n -: 15];
                default: p = p;
            endcase
        end
        if (fmt == FMT_TEST)
            for (int n = 0; n < 48; n++)
                p[479 - 8 * n -: 8] = 8'(n);
        return p;
    endfunction

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            meta_r <= '0;
            sync_r <= '0;
            prev_r <= '0;
        end
        else
        begin
            meta_r <= {sampling_clock_i, sample_period_marker_i,
                converter_strobe_clock_i, conv_stream_i};
            sync_r <= meta_r;
            prev_r <= sync_r;
        end
    end

    afsl_cap_if cap0 ();
    afsl_cap_if cap1 ();
    assign cap0.strobe_edge = sync_r[16] & ~prev_r[16];
    assign cap0.marker = sync_r[18];
    assign cap0.data = sync_r[7:0];
    assign cap1.strobe_edge = sync_r[17] & ~prev_r[17];
    assign cap1.marker = sync_r[19];
    assign cap1.data = sync_r[15:8];
    afsl_capture u_cap0 (.clk_i(clk_i), .rst_i(rst_i), .cap(cap0));
    afsl_capture u_cap1 (.clk_i(clk_i), .rst_i(rst_i), .cap(cap1));

    // One character every ten clocks paces the whole frame read-out
    assign take = (bit_r == CHAR_LAST);
    assign samp_edge = sync_r[20] & ~prev_r[20];
    assign wb_wr = wb_cyc_i & wb_stb_i & wb_we_i & ack_r;
    assign link_rst = wb_wr && wb_adr_i == ADDR_CTRL && wb_sel_i[1] &&
        wb_dat_i[CTRL_LINK_RST];
    assign enc = afsl_enc(ch, chk, rd_r);

    always_comb
    begin
        ch = K28_1;
        chk = 1'b1;
        case (state_r)
            ST_SYNC, ST_COMMA: ch = K28_5;
            ST_HEAD:
                case (fmtf_r)
                    FMT_12: ch = K28_2;
                    FMT_14: ch = K28_3;
                    FMT_TEST: ch = K28_0;
                    default: ch = K28_6;
                endcase
            ST_STAMP:
            begin
                ch = tsf_r;
                chk = 1'b0;
            end
            ST_DATA:
            begin
                ch = frame_r[479:472];
                chk = 1'b0;
            end
            ST_PAR0:
            begin
                ch = par_r[15:8];
                chk = 1'b0;
            end
            ST_PAR1:
            begin
                ch = par_r[7:0];
                chk = 1'b0;
            end
            default: ch = K28_1;
        endcase
    end

    always_comb
    begin
        state_nxt = state_r;
        run_nxt = run_r;
        cnt_nxt = cnt_r;
        frame_nxt = frame_r;
        par_nxt = par_r;
        tsf_nxt = tsf_r;
        fmtf_nxt = fmtf_r;
        pend_nxt = pend_r;
        buf_nxt = buf_r;
        rd_nxt = rd_r;
        frames_nxt = frames_r;
        if (take)
        begin
            rd_nxt = enc[10];
            case (state_r)
                ST_SYNC:
                begin
                    run_nxt = run_r + 5'h01;
                    if (run_r == SYNC_RUN - 5'h01)
                        state_nxt = ST_IDLE;
                end
                // A frame starts only from idle, so raw frames always
                // get at least one K28.1 between them
                ST_IDLE:
                    if (pend_r == 2'b11)
                    begin
                        state_nxt = ST_HEAD;
                        fmtf_nxt = fmt_r;
                        tsf_nxt = ts_r;
                        frame_nxt = afsl_pack(buf_r, fmt_r);
                        par_nxt = 16'h0000;
                        pend_nxt = 2'b00;
                    end
                ST_HEAD: state_nxt = ST_STAMP;
                ST_STAMP:
                begin
                    state_nxt = ST_DATA;
                    cnt_nxt = 6'h00;
                end
                ST_DATA:
                begin
                    frame_nxt = {frame_r[471:0], 8'h00};
                    if (cnt_r[0])
                        par_nxt[7:0] = par_r[7:0] ^ ch;
                    else
                        par_nxt[15:8] = par_r[15:8] ^ ch;
                    cnt_nxt = cnt_r + 6'h01;
                    if (cnt_r == afsl_nbytes(fmtf_r) - 6'h01)
                    begin
                        frames_nxt = frames_r + 16'h0001;
                        state_nxt = (fmtf_r == FMT_RAW) ? ST_IDLE
                            : ST_PAR0;
                    end
                end
                ST_PAR0: state_nxt = ST_PAR1;
                ST_PAR1:
                begin
                    state_nxt = (fmtf_r == FMT_TEST) ? ST_IDLE
                        : ST_COMMA;
                    run_nxt = 5'h00;
                end
                ST_COMMA:
                begin
                    run_nxt = run_r + 5'h01;
                    if (run_r == COMMA_RUN - 5'h01)
                        state_nxt = ST_IDLE;
                end
                default: state_nxt = ST_SYNC;
            endcase
        end
        // A new period arriving as a frame starts keeps its flag
        if (cap0.valid)
        begin
            pend_nxt[0] = 1'b1;
            buf_nxt[511:256] = cap0.words;
        end
        if (cap1.valid)
        begin
            pend_nxt[1] = 1'b1;
            buf_nxt[255:0] = cap1.words;
        end
        if (link_rst)
        begin
            state_nxt = ST_SYNC;
            run_nxt = 5'h00;
            rd_nxt = 1'b0;
        end
    end

    // Even bits and odd bits come from separate five-bit halves
    always_comb
    begin
        bit_nxt = take ? 4'h0 : bit_r + 4'h1;
        even_nxt = even_r;
        odd_nxt = odd_r;
        if (bit_r[0])
        begin
            tx_nxt = odd_r[4];
            odd_nxt = {odd_r[3:0], 1'b0};
        end
        else
        begin
            tx_nxt = even_r[4];
            even_nxt = {even_r[3:0], 1'b0};
        end
        if (take)
        begin
            even_nxt = {enc[9], enc[7], enc[5], enc[3], enc[1]};
            odd_nxt = {enc[8], enc[6], enc[4], enc[2], enc[0]};
        end
        emph_nxt = emph_en_r & (tx_nxt != tx_r);
        ts_nxt = ts_r;
        if (sync_cmd_i)
            ts_nxt = 8'h00;
        else if (samp_edge)
            ts_nxt = ts_r + 8'h01;
    end

    // Format changes take effect at the next frame start only
    always_comb
    begin
        fmt_nxt = fmt_r;
        emph_en_nxt = emph_en_r;
        lvl_nxt = lvl_r;
        if (wb_wr && wb_adr_i == ADDR_CTRL && wb_sel_i[0])
        begin
            fmt_nxt = wb_dat_i[CTRL_FMT_LSB +: 2];
            emph_en_nxt = wb_dat_i[CTRL_EMPH_EN];
            lvl_nxt = wb_dat_i[CTRL_EMPH_LSB +: 3];
        end
        ack_nxt = wb_cyc_i & wb_stb_i & ~ack_r;
        dat_nxt = 32'h0000_0000;
        if (ack_nxt)
            case (wb_adr_i)
                ADDR_CTRL: dat_nxt = {25'h0, lvl_r, 1'b0, emph_en_r, fmt_r};
                ADDR_STAT: dat_nxt = {16'h0, ts_r, 2'b0, pend_r, 1'b0,
                    state_r};
                ADDR_FRAMES: dat_nxt = {16'h0, frames_r};
                default: dat_nxt = 32'h0000_0000;
            endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state_r <= ST_SYNC;
            run_r <= 5'h00;
            cnt_r <= 6'h00;
            frame_r <= '0;
            par_r <= 16'h0000;
            tsf_r <= 8'h00;
            fmtf_r <= FMT_RST;
            pend_r <= 2'b00;
            buf_r <= '0;
            rd_r <= 1'b0;
            frames_r <= 16'h0000;
            bit_r <= 4'h0;
            even_r <= 5'h00;
            odd_r <= 5'h00;
            tx_r <= 1'b0;
            emph_r <= 1'b0;
            ts_r <= 8'h00;
            fmt_r <= FMT_RST;
            emph_en_r <= EMPH_EN_RST;
            lvl_r <= EMPH_LVL_RST;
            ack_r <= 1'b0;
            dat_r <= 32'h0000_0000;
        end
        else
        begin
            state_r <= state_nxt;
            run_r <= run_nxt;
            cnt_r <= cnt_nxt;
            frame_r <= frame_nxt;
            par_r <= par_nxt;
            tsf_r <= tsf_nxt;
            fmtf_r <= fmtf_nxt;
            pend_r <= pend_nxt;
            buf_r <= buf_nxt;
            rd_r <= rd_nxt;
            frames_r <= frames_nxt;
            bit_r <= bit_nxt;
            even_r <= even_nxt;
            odd_r <= odd_nxt;
            tx_r <= tx_nxt;
            emph_r <= emph_nxt;
            ts_r <= ts_nxt;
            fmt_r <= fmt_nxt;
            emph_en_r <= emph_en_nxt;
            lvl_r <= lvl_nxt;
            ack_r <= ack_nxt;
            dat_r <= dat_nxt;
        end
    end

    assign wb_dat_o = dat_r;
    assign wb_ack_o = ack_r;
    assign tx_bit_o = tx_r;
    assign emph_pulse_o = emph_r;
    assign emph_en_o = emph_en_r;
    assign emph_level_o = lvl_r;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    a_head_k12: assert property (
        take && state_r == ST_HEAD && fmtf_r == FMT_12 |-> chk && ch == K28_2)
        else $error("12-bit frame header wrong");
    a_head_k14: assert property (
        take && state_r == ST_HEAD && fmtf_r == FMT_14 |-> chk && ch == K28_3)
        else $error("14-bit frame header wrong");
    a_head_test: assert property (
        take && state_r == ST_HEAD && fmtf_r == FMT_TEST
        |-> chk && ch == K28_0)
        else $error("test frame header wrong");
    a_raw_idle_gap: assert property (
        take && state_r == ST_DATA && fmtf_r == FMT_RAW &&
        cnt_r == NB_RAW - 6'h01
        |=> ##9 take && chk && ch == K28_1)
        else $error("raw frame not followed by idle");
    a_comma_after: assert property (
        take && state_r == ST_PAR1 && (fmtf_r == FMT_12 || fmtf_r == FMT_14)
        |=> ##9 take && chk && ch == K28_5)
        else $error("no comma after data frame");
    a_link_sync: assert property (
        link_rst |=> state_r == ST_SYNC ##[0:9] (take && ch == K28_5))
        else $error("link reset without comma run");
    a_char_tick: assert property (
        take |-> ##10 take)
        else $error("character period not ten clocks");
    a_emph_off: assert property (
        !emph_en_r |=> !emph_pulse_o)
        else $error("pre-emphasis active while off");
    a_ts_step: assert property (
        samp_edge && !sync_cmd_i |=> ts_r == $past(ts_r) + 8'h01)
        else $error("timestamp did not count");

    c_frame_12: cover property (
        take && state_r == ST_HEAD && fmtf_r == FMT_12);
    c_frame_raw: cover property (
        take && state_r == ST_HEAD && fmtf_r == FMT_RAW);
    c_comma_run: cover property (take && state_r == ST_COMMA);
    c_link_rst: cover property (link_rst);
endmodule
`default_nettype wire

// ===== verif/afsl_rx_model.sv
/*
  Receiver model of the serial line: finds the comma boundary and
  hands out each 10-bit character. Assumes one bit per clk, a first.
*/
`timescale 1ns/1ps
`default_nettype none
module afsl_rx_model
(
    // Clock, reset and line
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic bit_i,
    // Characters out
    output logic [9:0] char_o,
    output logic char_v_o
);
    logic [9:0] sh;
    logic [3:0] cnt;
    logic lock;
    wire logic [9:0] nx = {sh[8:0], bit_i};
    // Realign on every K28.5 comma; legal streams hold no misaligned comma
    always_ff @(posedge clk_i)
    begin
        sh <= nx;
        char_v_o <= 1'b0;
        cnt <= cnt + 4'h1;
        if (rst_i)
            lock <= 1'b0;
        else if (nx == 10'h0fa || nx == 10'h305 || (lock && cnt == 4'h9))
        begin
            lock <= 1'b1;
            cnt <= 4'h0;
            char_o <= nx;
            char_v_o <= 1'b1;
        end
    end
endmodule
`default_nettype wire

// ===== verif/test_afsl_framer.sv
/*
  Bench of the pair framer: register bus, converter streams, line.
  Assumes the receiver model aligns on commas.
*/
`timescale 1ns/1ps
`default_nettype none
module test_afsl_framer;
    import afsl_pkg::*;
    logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, ack, samp = 0;
    logic sync_cmd = 0, txb, ep, ee, rv;
    logic [7:0] adr = 0;
    logic [31:0] dat = 0, q, wdo, seed = 32'h559f820a;
    logic [15:0] strm = 0;
    logic [1:0] strb = 0, mark = 0;
    logic [2:0] el;
    logic [9:0] rc;
    logic [9:0] rxq[$];
    logic [3:0] k;
    int failures = 0, checks_done = 0, cyc_n = 0, ep_n = 0, n, n0;
    // Expected frame shape per format: header, non-K count, trailer
    logic [3:0] hd[4] = '{4'h5, 4'h3, 4'h4, 4'h6};
    int nd[4] = '{51, 59, 51, 61};
    logic [3:0] tl[4] = '{4'ha, 4'ha, 4'h9, 4'h9};
    afsl_framer u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
        .wb_dat_i(dat), .wb_dat_o(wdo), .wb_ack_o(ack),
        .conv_stream_i(strm), .converter_strobe_clock_i(strb),
        .sample_period_marker_i(mark), .sampling_clock_i(samp),
        .sync_cmd_i(sync_cmd), .tx_bit_o(txb), .emph_pulse_o(ep),
        .emph_en_o(ee), .emph_level_o(el));
    afsl_rx_model u_rx (.clk_i(clk_i), .rst_i(rst_i), .bit_i(txb),
        .char_o(rc), .char_v_o(rv));
    initial forever #5 clk_i = ~clk_i;
    always @(posedge clk_i)
    begin
        if (rv === 1'b1) rxq.push_back(rc);
        if (ep === 1'b1) ep_n++;
        cyc_n++;
        if (cyc_n == 30000) begin failures++; report_and_stop; end
    end
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    // K28 characters reduce to their RD- 4b code, data to f
    function automatic logic [3:0] kind(input logic [9:0] c);
        if (c[9:4] == 6'h0f) return c[3:0];
        if (c[9:4] == 6'h30) return ~c[3:0];
        return 4'hf;
    endfunction
    task report_and_stop;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task chk(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e)
        begin
            $display("[FAIL] %0t got %h exp %h", $time, g, e);
            failures++;
        end
    endtask
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        {cyc, stb, we, adr, dat} <= {1'b1, 1'b1, w, a, d};
        do @(posedge clk_i); while (ack !== 1'b1);
        q = wdo;
        {cyc, stb} <= 2'b00;
    endtask
    task next_k;
        while (rxq.size() == 0) @(posedge clk_i);
        k = kind(rxq.pop_front());
    endtask
    task sync_run;
        do next_k; while (k == 4'h9);
        n = 0;
        while (k == 4'ha) begin n++; next_k; end
        chk(n, SYNC_RUN);
        chk(k, 4'h9);
    endtask
    // Both converters, one sample period of 32 bits per stream
    task period;
        for (int i = 0; i < 32; i++)
        begin
            @(posedge clk_i);
            seed = lfsr(seed);
            strm <= seed[15:0];
            mark <= (i == 0) ? 2'b11 : 2'b00;
            strb <= 2'b00;
            repeat (4) @(posedge clk_i);
            strb <= 2'b11;
            repeat (3) @(posedge clk_i);
        end
        @(posedge clk_i);
        strb <= 2'b00;
    endtask
    initial
    begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(0, ADDR_CTRL, 0);
        chk(q, 32'h44);
        chk(ee, 1);
        chk(el, 4);
        wb(0, 8'hfc, 0);
        chk(q, 0);
        sync_run;
        @(posedge clk_i) sync_cmd <= 1'b1;
        @(posedge clk_i) sync_cmd <= 1'b0;
        repeat (3)
        begin
            repeat (4) @(posedge clk_i) samp <= 1'b1;
            repeat (4) @(posedge clk_i) samp <= 1'b0;
        end
        repeat (6) @(posedge clk_i);
        wb(0, ADDR_STAT, 0);
        chk(q[15:8], 3);
        chk(ep_n > 0, 1);
        for (int f = 0; f < 4; f++)
        begin
            wb(1, ADDR_CTRL, f);
            // The last pulse launched before the write lands still counts
            if (f == 0)
            begin
                repeat (2) @(posedge clk_i);
                n0 = ep_n;
            end
            period;
            rxq.delete();
            do next_k; while (k == 4'h9 || k == 4'ha);
            chk(k, hd[f]);
            n = 0;
            next_k;
            while (k == 4'hf) begin n++; next_k; end
            chk(n, nd[f]);
            chk(k, tl[f]);
        end
        chk(ee, 0);
        chk(el, 0);
        chk(ep_n, n0);
        wb(1, ADDR_CTRL, 32'h100);
        rxq.delete();
        sync_run;
        report_and_stop;
    end
endmodule
`default_nettype wire
